/* cmfc_pkg.sv */
// cmfc_pkg: shared constants and types for the message FIFO control block
package cmfc_pkg;
   // ------------------------------------------------------------
   // register selection (index on regSel)
   // ------------------------------------------------------------
   localparam logic [1:0] REG_CTRL_HIGH = 2'h0;
   localparam logic [1:0] REG_CTRL_LOW = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam int REG_W = 16;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   // control high
   localparam int PAYLOAD_LSB = 13;
   localparam int DEPTH_LSB = 8;
   localparam int RETRY_LSB = 5;
   localparam int PRIO_LSB = 0;
   // control low
   localparam int CLEAR_BIT = 10;
   localparam int SEND_BIT = 9;
   localparam int ADV_BIT = 8;
   localparam int DIR_BIT = 7;
   localparam int RTR_BIT = 6;
   localparam int TS_BIT = 5;
   // shared by enables (control low) and flags (status)
   localparam int EXH_BIT = 4;
   localparam int OVF_BIT = 3;
   localparam int EF_BIT = 2;
   localparam int HALF_BIT = 1;
   localparam int NFNE_BIT = 0;
   // status only
   localparam int INDEX_LSB = 8;
   localparam int ABORT_BIT = 7;
   localparam int ARB_BIT = 6;
   localparam int BERR_BIT = 5;

   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [1:0] RETRY_RESET = 2'h3;
   localparam logic CLEAR_RESET = 1'b1;
   localparam logic [2:0] MODE_CONFIG = 3'h4;

   // effective retransmission behaviour handed to the engine
   typedef enum logic [1:0] {
      RETRY_NONE = 2'h0,
      RETRY_THREE = 2'h1,
      RETRY_UNLIMITED = 2'h3
   } cmfc_retry_t;

   // data bytes per message object, indexed by the payload code
   localparam logic [6:0] PAYLOAD_BYTES [8] = '{7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
endpackage

/* cmfc_if.sv */
// cmfc_if: link between the FIFO control logic and the protocol engine
`timescale 1ns/100ps
`default_nettype none
interface cmfc_if (
   input wire logic clk,
   input wire logic reset
);
   import cmfc_pkg::*;
   // configuration and state driven by the FIFO control
   logic txMode;
   logic sendPending;
   logic abortRequest;
   logic [6:0] payloadBytes;
   logic [5:0] fifoDepth;
   cmfc_retry_t retryMode;
   logic [4:0] txPriority;
   logic timestampOn;
   logic [4:0] msgIndex;
   logic msgAvail;
   // events driven by the engine (one-cycle pulses)
   logic txDone;
   logic txAborted;
   logic txArbLost;
   logic txBusError;
   logic attemptsExhausted;
   logic rxStore;
   logic remoteReceived;

   modport device (
      input clk, reset,
      output txMode, sendPending, abortRequest, payloadBytes, fifoDepth, retryMode,
      output txPriority, timestampOn, msgIndex, msgAvail,
      input txDone, txAborted, txArbLost, txBusError, attemptsExhausted, rxStore, remoteReceived
   );
   modport engine (
      input clk, reset,
      input txMode, sendPending, abortRequest, payloadBytes, fifoDepth, retryMode,
      input txPriority, timestampOn, msgIndex, msgAvail,
      output txDone, txAborted, txArbLost, txBusError, attemptsExhausted, rxStore, remoteReceived
   );
endinterface
`default_nettype wire

/* cmfc_device.sv */
// cmfc_device: control, status and occupancy logic of one message FIFO
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module cmfc_device
   import cmfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // engine link
   cmfc_if.device link,
   // software register port
   input wire logic [1:0] regSel,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [REG_W-1:0] regWdata,
   output logic [REG_W-1:0] regRdata,
   // controller-wide settings
   input wire logic [2:0] operatingMode,
   input wire logic retryLimitEnable,
   // interrupt request
   output logic fifoIrq
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [2:0] payloadSize_reg;
   logic [4:0] fifoDepth_reg;
   logic [1:0] retryLimit_reg;
   logic [4:0] txPriority_reg;
   logic fifoClear_reg;
   logic sendRequest_reg;
   logic pointerAdvance_reg;
   logic directionSelect_reg;
   logic remoteAutoReply_reg;
   logic rxTimestamp_reg;
   logic [4:0] intEnable_reg;
   logic [5:0] count_reg;
   logic [4:0] index_reg;
   logic abortedStatus_reg;
   logic arbLost_reg;
   logic busError_reg;
   logic exhaustedFlag_reg;
   logic overflowFlag_reg;
   logic abortRequest_reg;
   logic [REG_W-1:0] rdData_reg;
   logic irq_reg;
   logic cfgWritable;
   logic wrHigh;
   logic wrLow;
   logic wrStatus;
   logic rdStatus;
   logic [5:0] depth;
   logic isFull;
   logic isEmpty;
   logic txDoneEv;
   logic abortEv;
   logic storeOk;
   logic overflowEv;
   logic advanceAct;
   logic countInc;
   logic countDec;
   logic indexStep;
   logic [4:0] flags;
   logic [REG_W-1:0] statusWord;

   // ------------------------------------------------------------
   // decode and live FIFO state
   // ------------------------------------------------------------
   assign cfgWritable = (operatingMode == MODE_CONFIG);
   assign wrHigh = regWrite && (regSel == REG_CTRL_HIGH);
   assign wrLow = regWrite && (regSel == REG_CTRL_LOW);
   assign wrStatus = regWrite && (regSel == REG_STATUS);
   assign rdStatus = regRead && (regSel == REG_STATUS);
   assign depth = {1'b0, fifoDepth_reg} + 6'h01;
   assign isFull = (count_reg == depth);
   assign isEmpty = (count_reg == 6'h00);
   // engine events only count in the matching direction
   assign txDoneEv = link.txDone && directionSelect_reg && !fifoClear_reg;
   assign abortEv = link.txAborted && directionSelect_reg && !fifoClear_reg;
   assign storeOk = link.rxStore && !directionSelect_reg && !isFull && !fifoClear_reg;
   assign overflowEv = link.rxStore && !directionSelect_reg && isFull && !fifoClear_reg;
   assign advanceAct = pointerAdvance_reg && !fifoClear_reg;
   // tx: software queues at head, engine drains; rx: engine stores, software drains
   assign countInc = directionSelect_reg ? (advanceAct && !isFull) : storeOk;
   assign countDec = directionSelect_reg ? (txDoneEv && !isEmpty) : (advanceAct && !isEmpty);
   assign indexStep = directionSelect_reg ? (txDoneEv && !isEmpty) : storeOk;

   // occupancy flags follow the direction
   always_comb
   begin
      flags = 5'h00;
      flags[EXH_BIT] = exhaustedFlag_reg && directionSelect_reg;
      flags[OVF_BIT] = overflowFlag_reg && !directionSelect_reg;
      if (directionSelect_reg)
      begin
         flags[EF_BIT] = isEmpty;
         flags[HALF_BIT] = ({count_reg, 1'b0} <= {1'b0, depth});
         flags[NFNE_BIT] = !isFull;
      end
      else
      begin
         flags[EF_BIT] = isFull;
         flags[HALF_BIT] = ({count_reg, 1'b0} >= {1'b0, depth});
         flags[NFNE_BIT] = !isEmpty;
      end
   end

   // status word as seen by software
   always_comb
   begin
      statusWord = '0;
      statusWord[INDEX_LSB +: 5] = index_reg;
      statusWord[ABORT_BIT] = abortedStatus_reg;
      statusWord[ARB_BIT] = arbLost_reg;
      statusWord[BERR_BIT] = busError_reg;
      statusWord[4:0] = flags;
   end

   // ------------------------------------------------------------
   // configuration fields, held outside configuration mode
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         payloadSize_reg <= 3'h0;
         fifoDepth_reg <= 5'h00;
         retryLimit_reg <= RETRY_RESET;
         txPriority_reg <= 5'h00;
         rxTimestamp_reg <= 1'b0;
      end
      else if (cfgWritable)
      begin
         if (wrHigh)
         begin
            payloadSize_reg <= regWdata[PAYLOAD_LSB +: 3];
            fifoDepth_reg <= regWdata[DEPTH_LSB +: 5];
            retryLimit_reg <= regWdata[RETRY_LSB +: 2];
            txPriority_reg <= regWdata[PRIO_LSB +: 5];
         end
         if (wrLow)
            rxTimestamp_reg <= regWdata[TS_BIT];
      end
   end

   // direction, auto reply and interrupt enables
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         directionSelect_reg <= 1'b0;
         remoteAutoReply_reg <= 1'b0;
         intEnable_reg <= 5'h00;
      end
      else if (wrLow)
      begin
         directionSelect_reg <= regWdata[DIR_BIT];
         remoteAutoReply_reg <= regWdata[RTR_BIT];
         intEnable_reg <= regWdata[4:0];
      end
   end

   // ------------------------------------------------------------
   // self-clearing command bits
   // ------------------------------------------------------------
   // clear bit: set by software, serviced one cycle later
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         fifoClear_reg <= CLEAR_RESET;
      else if (wrLow && regWdata[CLEAR_BIT])
         fifoClear_reg <= 1'b1;
      else
         fifoClear_reg <= 1'b0;
   end

   // advance bit: acts in the cycle after the write, then drops
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         pointerAdvance_reg <= 1'b0;
      else
         pointerAdvance_reg <= wrLow && regWdata[ADV_BIT];
   end

   // send request: sets win over every clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         sendRequest_reg <= 1'b0;
      else if (remoteAutoReply_reg && directionSelect_reg && link.remoteReceived)
         sendRequest_reg <= 1'b1;
      else if (wrLow && directionSelect_reg && regWdata[SEND_BIT])
         sendRequest_reg <= 1'b1;
      else if (fifoClear_reg || !directionSelect_reg)
         sendRequest_reg <= 1'b0;
      else if (wrLow)
         sendRequest_reg <= 1'b0;
      else if (abortEv || (txDoneEv && count_reg == 6'h01 && !countInc))
         sendRequest_reg <= 1'b0;
   end

   // abort pulse toward the engine on a zero written over a pending request
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         abortRequest_reg <= 1'b0;
      else
         abortRequest_reg <= wrLow && directionSelect_reg && sendRequest_reg && !regWdata[SEND_BIT];
   end

   // ------------------------------------------------------------
   // occupancy count and message index
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count_reg <= 6'h00;
         index_reg <= 5'h00;
      end
      else if (fifoClear_reg)
      begin
         count_reg <= 6'h00;
         index_reg <= 5'h00;
      end
      else
      begin
         if (countInc && !countDec)
            count_reg <= count_reg + 6'h01;
         else if (countDec && !countInc)
            count_reg <= count_reg - 6'h01;
         if (indexStep)
            index_reg <= (index_reg == fifoDepth_reg) ? 5'h00 : index_reg + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // status bits
   // ------------------------------------------------------------
   // arbitration and bus error: latched on completion or abort only
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         arbLost_reg <= 1'b0;
         busError_reg <= 1'b0;
      end
      else if (fifoClear_reg)
      begin
         arbLost_reg <= 1'b0;
         busError_reg <= 1'b0;
      end
      else if (txDoneEv || abortEv)
      begin
         arbLost_reg <= link.txArbLost;
         busError_reg <= link.txBusError;
      end
   end

   // aborted status: set wins over its clears
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         abortedStatus_reg <= 1'b0;
      else if (abortEv)
         abortedStatus_reg <= 1'b1;
      else if (txDoneEv || rdStatus || wrStatus || fifoClear_reg || (wrLow && regWdata[SEND_BIT]))
         abortedStatus_reg <= 1'b0;
   end

   // sticky event flags: software writes zero to clear, set wins
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         exhaustedFlag_reg <= 1'b0;
         overflowFlag_reg <= 1'b0;
      end
      else
      begin
         if (link.attemptsExhausted && directionSelect_reg)
            exhaustedFlag_reg <= 1'b1;
         else if (fifoClear_reg || (wrStatus && !regWdata[EXH_BIT]))
            exhaustedFlag_reg <= 1'b0;
         if (overflowEv)
            overflowFlag_reg <= 1'b1;
         else if (fifoClear_reg || (wrStatus && !regWdata[OVF_BIT]))
            overflowFlag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read data and interrupt
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rdData_reg <= '0;
      else if (regRead)
         unique case (regSel)
            REG_CTRL_HIGH: rdData_reg <= {payloadSize_reg, fifoDepth_reg, 1'b0, retryLimit_reg, txPriority_reg};
            REG_CTRL_LOW: rdData_reg <= {5'h00, fifoClear_reg, sendRequest_reg, pointerAdvance_reg,
               directionSelect_reg, remoteAutoReply_reg, rxTimestamp_reg, intEnable_reg};
            REG_STATUS: rdData_reg <= statusWord;
            default: rdData_reg <= '0; // unmapped index reads zero
         endcase
   end

   // interrupt request from any enabled flag
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(flags & intEnable_reg);
   end

   assign regRdata = rdData_reg;
   assign fifoIrq = irq_reg;

   // ------------------------------------------------------------
   // link outputs
   // ------------------------------------------------------------
   assign link.txMode = directionSelect_reg;
   assign link.sendPending = sendRequest_reg && directionSelect_reg;
   assign link.abortRequest = abortRequest_reg;
   assign link.payloadBytes = PAYLOAD_BYTES[payloadSize_reg];
   assign link.fifoDepth = depth;
   assign link.retryMode = !retryLimitEnable ? RETRY_UNLIMITED : (retryLimit_reg == 2'h0) ? RETRY_NONE :
      (retryLimit_reg == 2'h1) ? RETRY_THREE : RETRY_UNLIMITED;
   assign link.txPriority = txPriority_reg;
   assign link.timestampOn = rxTimestamp_reg && !directionSelect_reg;
   assign link.msgIndex = index_reg;
   assign link.msgAvail = directionSelect_reg ? !isEmpty : !isFull;
endmodule
`default_nettype wire

/* cmfc_engine.sv */
// cmfc_engine: protocol engine end of the FIFO control link
`timescale 1ns/100ps
`default_nettype none
module cmfc_engine
   import cmfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link toward the FIFO control
   cmfc_if.engine link,
   // event inputs from the protocol core (one-cycle pulses)
   input wire logic evTxDone,
   input wire logic evTxAborted,
   input wire logic evArbLost,
   input wire logic evBusError,
   input wire logic evExhausted,
   input wire logic evRxStore,
   input wire logic evRemote,
   // settings seen by the protocol core
   output logic txMode,
   output logic sendPending,
   output logic abortSeen,
   output logic [6:0] payloadBytes,
   output logic [5:0] fifoDepth,
   output cmfc_retry_t retryMode,
   output logic [4:0] txPriority,
   output logic timestampOn,
   output logic [4:0] msgIndex,
   output logic msgAvail
);
   logic [6:0] events_reg;
   logic [1:0] quals_reg;

   // ------------------------------------------------------------
   // event pulses onto the link, one cycle after the core raises them
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         events_reg <= 7'h00;
         quals_reg <= 2'h0;
      end
      else
      begin
         events_reg <= {evTxDone, evTxAborted, evExhausted, evRxStore, evRemote, 2'h0} >> 2;
         quals_reg <= {evArbLost, evBusError};
      end
   end

   assign link.txDone = events_reg[4];
   assign link.txAborted = events_reg[3];
   assign link.attemptsExhausted = events_reg[2];
   assign link.rxStore = events_reg[1];
   assign link.remoteReceived = events_reg[0];
   assign link.txArbLost = quals_reg[1];
   assign link.txBusError = quals_reg[0];

   // ------------------------------------------------------------
   // settings registered toward the core
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         txMode <= 1'b0;
         sendPending <= 1'b0;
         abortSeen <= 1'b0;
         payloadBytes <= 7'h00;
         fifoDepth <= 6'h00;
         retryMode <= RETRY_UNLIMITED;
         txPriority <= 5'h00;
         timestampOn <= 1'b0;
         msgIndex <= 5'h00;
         msgAvail <= 1'b0;
      end
      else
      begin
         txMode <= link.txMode;
         sendPending <= link.sendPending;
         abortSeen <= link.abortRequest;
         payloadBytes <= link.payloadBytes;
         fifoDepth <= link.fifoDepth;
         retryMode <= link.retryMode;
         txPriority <= link.txPriority;
         timestampOn <= link.timestampOn;
         msgIndex <= link.msgIndex;
         msgAvail <= link.msgAvail;
      end
   end
endmodule
`default_nettype wire

/* cmfc_properties.sv */
// cmfc_properties: checks on the FIFO control link
`timescale 1ns/100ps
`default_nettype none
module cmfc_properties
   import cmfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // link signals
   input wire logic txMode,
   input wire logic sendPending,
   input wire logic abortRequest,
   input wire logic [6:0] payloadBytes,
   input wire logic [5:0] fifoDepth,
   input wire cmfc_retry_t retryMode,
   input wire logic timestampOn,
   input wire logic [4:0] msgIndex,
   input wire logic msgAvail,
   input wire logic txDone,
   input wire logic rxStore
);
   // index one message on, wrapping at the depth
   logic [5:0] idxNext;
   assign idxNext = (6'(msgIndex) + 6'h01 == fifoDepth) ? 6'h00 : 6'(msgIndex) + 6'h01;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // a message leaves a transmit FIFO or lands in a receive FIFO
   sequence txStep;
      txDone && txMode && msgAvail;
   endsequence
   sequence rxStep;
      rxStore && !txMode && msgAvail;
   endsequence
   payload_code_a: assert property (payloadBytes inside {7'h08,7'h0c,7'h10,7'h14,7'h18,7'h20,7'h30,7'h40})
      else $error("bad payload size");
   depth_range_a: assert property (fifoDepth != 6'h00 && fifoDepth <= 6'h20)
      else $error("bad depth");
   retry_code_a: assert property (retryMode != 2'h2)
      else $error("bad retry mode");
   abort_pulse_a: assert property (abortRequest |-> !sendPending ##1 !abortRequest)
      else $error("abort not one pulse");
   send_rx_a: assert property (!txMode |-> !sendPending)
      else $error("send pending in receive");
   stamp_rx_a: assert property (timestampOn |-> !txMode)
      else $error("timestamp in transmit");
   tx_index_a: assert property (txStep |=> 6'(msgIndex) == $past(idxNext))
      else $error("transmit index stuck");
   rx_index_a: assert property (rxStep |=> 6'(msgIndex) == $past(idxNext))
      else $error("receive index stuck");
endmodule
`default_nettype wire

/* can_message_fifo_control_tb.sv */
// can_message_fifo_control_tb: random traffic against a queue model
`timescale 1ns/100ps
`default_nettype none
module can_message_fifo_control_tb
   import cmfc_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] regSel = 2'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regWdata = 16'h0000;
   logic [15:0] regRdata;
   logic [2:0] operatingMode = 3'h4;
   logic retryLimitEnable = 1'b1;
   logic fifoIrq;
   logic [6:0] ev = 7'h00;
   int errorCnt = 0;
   int totalChecks = 0;
   int seed = 31910;
   int op, k, cnt = 0, idx = 0, depth = 1;
   int bytes [8] = '{8, 12, 16, 20, 24, 32, 48, 64};
   logic snd = 1'b0, abt = 1'b0, arb = 1'b0, ber = 1'b0, exh = 1'b0, ovf = 1'b0, dir = 1'b0;
   logic [4:0] ie = 5'h00;
   logic [15:0] hi, st;
   logic [31:0] r;
   logic [4:0] engIdx;
   logic engSnd;
   logic engTs;
   // clock
   always #10 clk = ~clk;
   // both ends joined by the link
   cmfc_if lnk (.clk(clk), .reset(reset));
   cmfc_device u_cmfc_device (.clk(clk), .reset(reset), .link(lnk), .regSel(regSel), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .operatingMode(operatingMode),
      .retryLimitEnable(retryLimitEnable), .fifoIrq(fifoIrq));
   cmfc_engine u_cmfc_engine (.clk(clk), .reset(reset), .link(lnk), .evTxDone(ev[0]), .evTxAborted(ev[1]),
      .evArbLost(ev[2]), .evBusError(ev[3]), .evExhausted(ev[4]), .evRxStore(ev[5]), .evRemote(ev[6]),
      .txMode(), .sendPending(engSnd), .abortSeen(), .payloadBytes(), .fifoDepth(), .retryMode(), .txPriority(),
      .timestampOn(engTs), .msgIndex(engIdx), .msgAvail());
   cmfc_properties u_cmfc_properties (.clk(clk), .reset(reset), .txMode(lnk.txMode),
      .sendPending(lnk.sendPending), .abortRequest(lnk.abortRequest), .payloadBytes(lnk.payloadBytes),
      .fifoDepth(lnk.fifoDepth), .retryMode(lnk.retryMode), .timestampOn(lnk.timestampOn),
      .msgIndex(lnk.msgIndex), .msgAvail(lnk.msgAvail), .txDone(lnk.txDone), .rxStore(lnk.rxStore));
   // comparison and verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic endOfTest();
      if (errorCnt == 0 && totalChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one register access or event pulse, then idle until all reactions land
   task automatic acc(input logic [1:0] sel, input logic wr, input logic [15:0] d);
      regSel = sel;
      regWrite = wr;
      regRead = !wr;
      regWdata = d;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic evt(input logic [6:0] e);
      ev = e;
      @(posedge clk);
      #1;
      ev = 7'h00;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rdchk(input logic [1:0] sel, input logic [15:0] exp);
      acc(sel, 1'b0, 16'h0000);
      chk(regRdata, exp);
   endtask
   // expected register images
   function automatic logic [15:0] status();
      logic ef, hf, nf;
      ef = dir ? cnt == 0 : cnt == depth;
      hf = dir ? 2 * cnt <= depth : 2 * cnt >= depth;
      nf = dir ? cnt != depth : cnt != 0;
      return {3'h0, 5'(idx), abt, arb, ber, exh, ovf, ef, hf, nf};
   endfunction
   function automatic logic [15:0] ctl(input logic s, input logic a, input logic c);
      return {5'h00, c, s, a, dir, dir, 1'b0, ie};
   endfunction
   // watchdog
   initial
   begin
      repeat (40000) @(posedge clk);
      errorCnt++;
      endOfTest();
   end
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      @(posedge clk);
      #1;
      k = 0;
      do
      begin
         acc(REG_CTRL_LOW, 1'b0, 16'h0000);
         k++;
      end
      while (regRdata[CLEAR_BIT] !== 1'b0 && k < 8);
      chk(regRdata, 16'h0000);
      rdchk(REG_CTRL_HIGH, 16'h0060);
      rdchk(2'h3, 16'h0000); // unmapped index
      rdchk(REG_STATUS, status());
      for (int c = 0; c < 8; c++)
      begin
         r = $random(seed);
         retryLimitEnable = r[16];
         hi = {3'(c), r[12:8], 1'b0, r[6:0]};
         acc(REG_CTRL_HIGH, 1'b1, hi);
         rdchk(REG_CTRL_HIGH, hi);
         chk(16'(lnk.payloadBytes), 16'(bytes[c]));
         chk(16'(lnk.fifoDepth), 16'(hi[12:8]) + 16'h0001);
         chk(16'(lnk.retryMode), (!retryLimitEnable || hi[6]) ? 16'h0003 : 16'(hi[5]));
      end
      operatingMode = 3'h0;
      acc(REG_CTRL_HIGH, 1'b1, ~hi);
      rdchk(REG_CTRL_HIGH, hi);
      operatingMode = 3'h4;
      acc(REG_CTRL_HIGH, 1'b1, 16'h0360);
      // timestamp enable only takes effect in configuration mode and in receive
      acc(REG_CTRL_LOW, 1'b1, 16'h0020);
      chk(16'(engTs), 16'h0001);
      acc(REG_CTRL_LOW, 1'b1, 16'h00a0);
      chk(16'(lnk.timestampOn), 16'h0000);
      acc(REG_CTRL_LOW, 1'b1, 16'h0000);
      depth = 4;
      operatingMode = 3'h0;
      for (int p = 0; p < 2; p++)
      begin
         dir = p[0];
         ie = 5'($random(seed));
         acc(REG_CTRL_LOW, 1'b1, ctl(1'b0, 1'b0, 1'b1));
         cnt = 0;
         idx = 0;
         {snd, abt, arb, ber, exh, ovf} = 6'h00;
         rdchk(REG_CTRL_LOW, ctl(1'b0, 1'b0, 1'b0));
         for (int n = 0; n < 150; n++)
         begin
            op = $unsigned($random(seed)) % 6;
            r = $random(seed);
            if (op == 0)
            begin
               acc(REG_CTRL_LOW, 1'b1, ctl(snd, 1'b1, 1'b0));
               cnt = dir ? (cnt < depth ? cnt + 1 : cnt) : (cnt > 0 ? cnt - 1 : cnt);
            end
            else if (op == 1 && !dir)
            begin
               evt(7'h20);
               ovf = ovf | (cnt == depth);
               idx = cnt == depth ? idx : (idx + 1) % depth;
               cnt = cnt == depth ? cnt : cnt + 1;
            end
            else if (op == 1 && snd)
            begin
               evt({3'h0, r[1:0], 2'h1});
               {ber, arb, abt} = {r[1:0], 1'b0};
               idx = (idx + 1) % depth;
               cnt--;
               snd = cnt != 0;
            end
            else if (op == 2)
            begin
               st = status();
               rdchk(REG_STATUS, st);
               abt = 1'b0;
               chk(16'(fifoIrq), 16'(|(st[4:0] & ie)));
               chk(16'(engIdx), 16'(idx));
               chk(16'(engSnd), 16'(snd & dir));
               rdchk(REG_CTRL_LOW, ctl(snd, 1'b0, 1'b0));
            end
            else if (op == 3 && dir && snd)
            begin
               acc(REG_CTRL_LOW, 1'b1, ctl(1'b0, 1'b0, 1'b0));
               evt({3'h0, r[1:0], 2'h2});
               {ber, arb, abt, snd} = {r[1:0], 2'h2};
            end
            else if (op == 3 && (cnt > 0 || !dir))
            begin
               if (dir && !abt && r[2])
                  evt(7'h40);
               else
                  acc(REG_CTRL_LOW, 1'b1, ctl(1'b1, 1'b0, 1'b0));
               snd = dir;
               abt = 1'b0;
            end
            else if (op == 4)
            begin
               evt(dir ? 7'h10 : 7'h40);
               exh = exh | dir;
            end
            else if (op == 5)
            begin
               acc(REG_STATUS, 1'b1, 16'h0000);
               {abt, exh, ovf} = 3'h0;
            end
         end
      end
      endOfTest();
   end
endmodule
`default_nettype wire
